/* common/adc_port_pkg.sv */
`default_nettype none

package adc_port_pkg;

   // register widths
   localparam int DATA_W   = 24;
   localparam int MODE_W   = 16;
   localparam int FILTER_W = 16;
   localparam int CAL_W    = 24;
   localparam int STATUS_W = 8;
   localparam int CMD_W    = 8;
   localparam int SEL_W    = 3;
   localparam int CNT_W    = 5;
   localparam int FIFO_DEPTH = 16;

   // register select codes in the command byte
   localparam logic [2:0] SEL_CMD_STATUS = 3'h0;
   localparam logic [2:0] SEL_DATA       = 3'h1;
   localparam logic [2:0] SEL_MODE       = 3'h2;
   localparam logic [2:0] SEL_FILTER     = 3'h3;
   localparam logic [2:0] SEL_OFFSET     = 3'h4;
   localparam logic [2:0] SEL_GAIN       = 3'h5;

   // command byte fields
   localparam int CMD_SEL_LSB  = 0;
   localparam int CMD_READ_BIT = 4;

   // mode register fields
   localparam int MODE_CAL_BIT = 15;

   // status register fields
   localparam int STAT_READY_BIT   = 7;
   localparam int STAT_STANDBY_BIT = 6;
   localparam int STAT_CAL_BIT     = 5;
   localparam int STAT_FULL_BIT    = 4;

   // transfer lengths in bits
   localparam logic [4:0] LEN_CMD  = 5'h08;
   localparam logic [4:0] LEN_8    = 5'h08;
   localparam logic [4:0] LEN_16   = 5'h10;
   localparam logic [4:0] LEN_24   = 5'h18;

   // reset values
   localparam logic [7:0]  CMD_RST    = 8'h00;
   localparam logic [15:0] MODE_RST   = 16'h0000;
   localparam logic [15:0] FILTER_RST = 16'h0000;
   localparam logic [23:0] CAL_RST    = 24'h000000;
   localparam logic [23:0] DATA_RST   = 24'h000000;

   // ready stays high this long before an unread result is replaced
   localparam int CLK_PERIOD_NS = 20;
   localparam int UPDATE_HOLD_NS = 1000;
   localparam int HOLD_CYCLES = (UPDATE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_EMPTY,
      ST_FULL,
      ST_HOLD,
      ST_CAL,
      ST_CAL_OK
   } ready_state_t;

   typedef enum logic [1:0] {
      PH_CMD,
      PH_READ,
      PH_WRITE
   } phase_t;

endpackage : adc_port_pkg

`default_nettype wire

/* rtl/result_fifo.sv */
`default_nettype none

module result_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk_in,
   input  wire logic             reset_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic      [WIDTH-1:0] out_data_out,
   input  wire logic             out_ready_in
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   wire              push = in_valid_in & in_ready_out;
   wire              fetch = (count != '0) & (~out_valid_out | out_ready_in);

   // ready is registered so the filler sees a flop, set one cycle early
   assign next_count = count + CNT_W'(push) - CNT_W'(fetch);

   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   // output word sits in a register ahead of the memory
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         wr_ptr        <= '0;
         rd_ptr        <= '0;
         count         <= '0;
         in_ready_out  <= 1'b0;
         out_valid_out <= 1'b0;
         out_data_out  <= '0;
      end else begin
         count        <= next_count;
         in_ready_out <= next_count != FULL_CNT;
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (fetch) begin
            out_data_out  <= mem[rd_ptr];
            out_valid_out <= 1'b1;
            rd_ptr        <= rd_ptr + 1'b1;
         end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
         end
      end
   end

endmodule : result_fifo

`default_nettype wire

/* rtl/adc_ready_readout_port.sv */
// How it works
// - low power-down input halts the serial and ready logic; the result buffer still accepts results
// - registers keep their contents while halted
// - chip select low enables serial transfers
// - tied-low select works with three wires
// - ready goes low on fresh result
// - ready goes high after full word read
// - unread result: ready high around update
// - calibration: ready high, low when done
// - output shifter loaded from selected register
// - input shifter writes selected register
`default_nettype none

module adc_ready_readout_port #(
   parameter int DATA_W = adc_port_pkg::DATA_W,
   parameter int DEPTH  = adc_port_pkg::FIFO_DEPTH
) (
   input  wire logic              ref_clk_in,
   input  wire logic              reset_in,
   input  wire logic              standby_n_in,
   input  wire logic              cs_n_in,
   input  wire logic              sclk_in,
   input  wire logic              din_in,
   input  wire logic              result_valid_in,
   input  wire logic [DATA_W-1:0] result_data_in,
   output logic                   result_ready_out,
   input  wire logic              cal_done_in,
   output logic                   dout_out,
   output logic                   dout_oe_out,
   output logic                   rdy_n_out,
   output logic                   standby_out,
   output logic                   cal_start_out,
   output logic            [15:0] mode_out,
   output logic            [15:0] filter_out
);

   // bit count of each register as seen on the wire
   function automatic logic [4:0] reg_len(input logic [2:0] sel);
      case (sel)
         adc_port_pkg::SEL_DATA,
         adc_port_pkg::SEL_OFFSET,
         adc_port_pkg::SEL_GAIN:   reg_len = adc_port_pkg::LEN_24;
         adc_port_pkg::SEL_MODE,
         adc_port_pkg::SEL_FILTER: reg_len = adc_port_pkg::LEN_16;
         default:                  reg_len = adc_port_pkg::LEN_8;
      endcase
   endfunction : reg_len

   // two-flop synchronisers for every pin; stage one feeds only stage two
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic       sclk_d;

   always_ff @(posedge ref_clk_in) begin
      // idle pin levels, so reset shows no false standby, select or clock edge
      if (reset_in) begin
         pin_s1 <= 4'hE;
         pin_s2 <= 4'hE;
         sclk_d <= 1'b1;
      end else begin
         pin_s1 <= {standby_n_in, cs_n_in, sclk_in, din_in};
         pin_s2 <= pin_s1;
         sclk_d <= pin_s2[1];
      end
   end

   wire awake     = pin_s2[3];
   wire cs_s2     = pin_s2[2];
   wire sclk_s2   = pin_s2[1];
   wire din_s2    = pin_s2[0];
   wire sclk_rise = sclk_s2 & ~sclk_d;
   wire sclk_fall = ~sclk_s2 & sclk_d;
   wire selected  = ~cs_s2 & awake;

   // registers kept through standby
   logic [7:0]  cmd;
   logic [15:0] mode;
   logic [15:0] filter;
   logic [23:0] offset;
   logic [23:0] gain;
   logic [23:0] data;

   // serial engine state
   adc_port_pkg::phase_t phase;
   logic [4:0]  bit_cnt;
   logic [23:0] in_sh;
   logic [23:0] out_sh;
   logic        data_read_done;

   // ready tracking
   adc_port_pkg::ready_state_t state;
   adc_port_pkg::ready_state_t next_state;
   logic [7:0]  hold_cnt;

   // fifo hookup
   logic        fifo_valid;
   logic [23:0] fifo_data;
   logic        fifo_full;

   // decode of the serial stream
   wire [2:0]  sel        = cmd[adc_port_pkg::CMD_SEL_LSB +: adc_port_pkg::SEL_W];
   wire [4:0]  xfer_len   = (phase == adc_port_pkg::PH_CMD) ? adc_port_pkg::LEN_CMD : reg_len(sel);
   wire        bit_last   = selected & sclk_rise & (bit_cnt == xfer_len - 5'h01);
   wire [23:0] word       = {in_sh[22:0], din_s2};
   wire [2:0]  new_sel    = word[adc_port_pkg::CMD_SEL_LSB +: adc_port_pkg::SEL_W];
   wire        new_read   = word[adc_port_pkg::CMD_READ_BIT];
   wire        new_write  = (new_sel == adc_port_pkg::SEL_MODE) | (new_sel == adc_port_pkg::SEL_FILTER) |
                            (new_sel == adc_port_pkg::SEL_OFFSET) | (new_sel == adc_port_pkg::SEL_GAIN);
   wire        cmd_done   = bit_last & (phase == adc_port_pkg::PH_CMD);
   wire        write_done = bit_last & (phase == adc_port_pkg::PH_WRITE);
   wire        reading    = (phase == adc_port_pkg::PH_READ) & (sel == adc_port_pkg::SEL_DATA);
   wire        cal_go     = write_done & (sel == adc_port_pkg::SEL_MODE) & word[adc_port_pkg::MODE_CAL_BIT];
   wire        conv_go    = write_done & (sel == adc_port_pkg::SEL_MODE) & ~word[adc_port_pkg::MODE_CAL_BIT];

   // status word shows the block's own state
   wire [7:0] status = {~rdy_n_out, ~awake,
                        (state == adc_port_pkg::ST_CAL), fifo_full, 4'h0};

   // value to send, left aligned so the msb leaves first
   logic [23:0] rd_value;
   always_comb begin
      case (new_sel)
         adc_port_pkg::SEL_DATA:   rd_value = data;
         adc_port_pkg::SEL_MODE:   rd_value = {8'h00, mode};
         adc_port_pkg::SEL_FILTER: rd_value = {8'h00, filter};
         adc_port_pkg::SEL_OFFSET: rd_value = offset;
         adc_port_pkg::SEL_GAIN:   rd_value = gain;
         default:                  rd_value = {16'h0000, status};
      endcase
   end
   wire [23:0] rd_word = rd_value << (adc_port_pkg::LEN_24 - reg_len(new_sel));

   // serial shifting; bits in on sclk rise, out on sclk fall
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         phase          <= adc_port_pkg::PH_CMD;
         bit_cnt        <= '0;
         in_sh          <= '0;
         out_sh         <= '0;
         dout_out       <= 1'b0;
         dout_oe_out    <= 1'b0;
         data_read_done <= 1'b0;
      end else begin
         dout_oe_out    <= selected;
         data_read_done <= 1'b0;
         if (!awake) begin
            // frozen in standby, nothing moves
         end else if (cs_s2) begin
            phase   <= adc_port_pkg::PH_CMD;
            bit_cnt <= '0;
         end else if (sclk_rise) begin
            in_sh   <= word;
            bit_cnt <= bit_last ? 5'h00 : bit_cnt + 5'h01;
            if (cmd_done && new_read) begin
               phase  <= adc_port_pkg::PH_READ;
               out_sh <= rd_word;
            end else if (cmd_done) begin
               phase  <= new_write ? adc_port_pkg::PH_WRITE : adc_port_pkg::PH_CMD;
            end else if (bit_last) begin
               phase          <= adc_port_pkg::PH_CMD;
               data_read_done <= reading;
            end
         end else if (sclk_fall && phase == adc_port_pkg::PH_READ) begin
            dout_out <= out_sh[23];
            out_sh   <= {out_sh[22:0], 1'b0};
         end
      end
   end

   // register writes; only a finished word changes anything
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         cmd    <= adc_port_pkg::CMD_RST;
         mode   <= adc_port_pkg::MODE_RST;
         filter <= adc_port_pkg::FILTER_RST;
         offset <= adc_port_pkg::CAL_RST;
         gain   <= adc_port_pkg::CAL_RST;
      end else begin
         if (cmd_done) begin
            cmd <= word[7:0];
         end
         if (write_done) begin
            case (sel)
               adc_port_pkg::SEL_MODE:   mode   <= word[15:0];
               adc_port_pkg::SEL_FILTER: filter <= word[15:0];
               adc_port_pkg::SEL_OFFSET: offset <= word;
               adc_port_pkg::SEL_GAIN:   gain   <= word;
               default:                  cmd    <= cmd;
            endcase
         end
      end
   end

   // a new result replaces the data register only outside a data read
   wire hold_over = (hold_cnt == 8'h00);
   wire pop = awake & fifo_valid & ~reading &
              ((state == adc_port_pkg::ST_EMPTY) | ((state == adc_port_pkg::ST_HOLD) & hold_over));

   // ready sequencing for conversions and calibration
   always_comb begin
      next_state = state;
      if (!awake) begin
         next_state = state;
      end else if (cal_go) begin
         next_state = adc_port_pkg::ST_CAL;
      end else begin
         case (state)
            adc_port_pkg::ST_EMPTY: begin
               if (pop) next_state = adc_port_pkg::ST_FULL;
            end
            adc_port_pkg::ST_FULL: begin
               if (data_read_done) begin
                  next_state = adc_port_pkg::ST_EMPTY;
               end else if (fifo_valid && !reading) begin
                  next_state = adc_port_pkg::ST_HOLD;
               end
            end
            adc_port_pkg::ST_HOLD: begin
               if (pop) next_state = adc_port_pkg::ST_FULL;
            end
            adc_port_pkg::ST_CAL: begin
               if (cal_done_in) next_state = adc_port_pkg::ST_CAL_OK;
            end
            adc_port_pkg::ST_CAL_OK: begin
               if (data_read_done || conv_go) next_state = adc_port_pkg::ST_EMPTY;
            end
            default: next_state = adc_port_pkg::ST_EMPTY;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         state         <= adc_port_pkg::ST_EMPTY;
         rdy_n_out     <= 1'b1;
         hold_cnt      <= '0;
         data          <= adc_port_pkg::DATA_RST;
         cal_start_out <= 1'b0;
         standby_out   <= 1'b0;
      end else begin
         state         <= next_state;
         rdy_n_out     <= ~(next_state == adc_port_pkg::ST_FULL ||
                            next_state == adc_port_pkg::ST_CAL_OK);
         cal_start_out <= cal_go;
         standby_out   <= ~awake;
         if (pop) begin
            data <= fifo_data;
         end
         // the hold window gives a read in flight time to be seen
         if (state == adc_port_pkg::ST_FULL && next_state == adc_port_pkg::ST_HOLD) begin
            hold_cnt <= 8'(adc_port_pkg::HOLD_CYCLES - 1);
         end else if (awake && !hold_over) begin
            hold_cnt <= hold_cnt - 8'h01;
         end
      end
   end

   // result buffer between converter core and data register
   result_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .ref_clk_in    (ref_clk_in),
      .reset_in      (reset_in),
      .in_valid_in   (result_valid_in),
      .in_data_in    (result_data_in),
      .in_ready_out  (result_ready_out),
      .out_valid_out (fifo_valid),
      .out_data_out  (fifo_data),
      .out_ready_in  (pop)
   );

   assign fifo_full  = ~result_ready_out;
   assign mode_out   = mode;
   assign filter_out = filter;

   // checks
   chk_standby_flag: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      !awake |=> standby_out && $stable(state))
      else $error("standby not reported or state moved");
   chk_standby_keep: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      !awake |=> $stable(mode) && $stable(filter) && $stable(offset) && $stable(gain) && $stable(data))
      else $error("register changed in standby");
   chk_select_idle: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (cs_s2 && awake) |=> bit_cnt == 5'h00 && phase == adc_port_pkg::PH_CMD && !dout_oe_out)
      else $error("serial engine active while deselected");
   chk_fresh_low: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (state == adc_port_pkg::ST_EMPTY && pop && !cal_go) |=> !rdy_n_out && data == $past(fifo_data))
      else $error("fresh result not flagged");
   chk_read_high: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (data_read_done && awake && (state == adc_port_pkg::ST_FULL || state == adc_port_pkg::ST_CAL_OK)) |=> rdy_n_out)
      else $error("ready low after full read");
   chk_hold_window: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      $changed(data) |-> $past(rdy_n_out) && !$past(reading))
      else $error("data register replaced while ready low or read in flight");
   chk_cal_sequence: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      cal_go |=> rdy_n_out && cal_start_out && state == adc_port_pkg::ST_CAL)
      else $error("ready low during calibration");
   chk_cal_done: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (state == adc_port_pkg::ST_CAL && cal_done_in && awake && !cal_go) |=> !rdy_n_out)
      else $error("ready not low after calibration");
   chk_out_load: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (cmd_done && new_read) |=> out_sh == $past(rd_word) && phase == adc_port_pkg::PH_READ)
      else $error("output shifter not loaded");
   chk_mode_write: assert property (@(posedge ref_clk_in) disable iff (reset_in)
      (write_done && sel == adc_port_pkg::SEL_MODE) |=> mode == $past(word[15:0]))
      else $error("mode register not written");

endmodule : adc_ready_readout_port

`default_nettype wire

/* bench/serial_host.sv */
`default_nettype none

module serial_host (
   output logic      cs_n_out,
   output logic      sclk_out,
   output logic      din_out,
   input  wire logic dout_in,
   input  wire logic dout_oe_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle: deselected, clock parked high between frames
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b1;
      din_out  = 1'b0;
   end

   // n bits msb first at 160 ns, data read back before each falling edge
   task automatic frame(input logic [31:0] bits, input int n, input bit keep_sel,
                        output logic [31:0] got);
      got = 32'h00000000;
      #7;
      cs_n_out = 1'b0;
      #80;
      for (int i = n - 1; i >= 0; i--) begin
         sclk_out = 1'b0;
         din_out  = bits[i];
         #80;
         sclk_out = 1'b1;
         #80;
         got = {got[30:0], dout_oe_in ? dout_in : 1'bx};
      end
      // released line must not look like a held bit
      din_out = ~din_out;
      if (!keep_sel) begin
         cs_n_out = 1'b1;
      end
      #80;
   endtask : frame
endmodule : serial_host

`default_nettype wire

/* bench/adc_ready_readout_port_tb.sv */
`default_nettype none

module adc_ready_readout_port_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk_in;
   logic        reset_in;
   logic        standby_n_in;
   logic        result_valid_in;
   logic [23:0] result_data_in;
   logic        cal_done_in;
   wire logic   cs_n;
   wire logic   sclk;
   wire logic   din;
   logic        result_ready_out;
   logic        dout_out;
   logic        dout_oe_out;
   logic        rdy_n_out;
   logic        standby_out;
   logic        cal_start_out;
   logic [15:0] mode_out;
   logic [15:0] filter_out;
   int          miscompares = 0;
   int          compares = 0;
   int          cycles = 0;
   int          cal_pulses = 0;
   int          n;
   int          cp;
   logic [31:0] g;
   logic [23:0] v;
   logic [23:0] d;
   logic [23:0] e;
   logic [15:0] fv;
   logic [15:0] mv;

   adc_ready_readout_port #(.DATA_W(24), .DEPTH(adc_port_pkg::FIFO_DEPTH)) adc_ready_readout_port_inst (
      .ref_clk_in(ref_clk_in), .reset_in(reset_in), .standby_n_in(standby_n_in),
      .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din), .result_valid_in(result_valid_in),
      .result_data_in(result_data_in), .result_ready_out(result_ready_out),
      .cal_done_in(cal_done_in), .dout_out(dout_out), .dout_oe_out(dout_oe_out),
      .rdy_n_out(rdy_n_out), .standby_out(standby_out), .cal_start_out(cal_start_out),
      .mode_out(mode_out), .filter_out(filter_out)
   );

   serial_host serial_host_inst (
      .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din), .dout_in(dout_out), .dout_oe_in(dout_oe_out)
   );

   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   // cycle budget and calibration request count
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cal_start_out === 1'b1) begin
         cal_pulses <= cal_pulses + 1;
      end
      if (cycles == 30000) begin
         miscompares++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [7:0] cmd(input logic rd, input logic [2:0] sel);
      logic [7:0] c;
      c = 8'h00;
      c[adc_port_pkg::CMD_READ_BIT] = rd;
      c[2:0] = sel;
      return c;
   endfunction : cmd

   // whole command plus n-bit word in one select frame
   task automatic xfer(input logic rd, input logic [2:0] sel, input logic [23:0] wv, input int nb,
                       output logic [23:0] val);
      logic [31:0] got;
      serial_host_inst.frame(({24'h000000, cmd(rd, sel)} << nb) | {8'h00, wv}, 8 + nb, 1'b0, got);
      val = got[23:0];
      @(negedge ref_clk_in);
   endtask : xfer

   task automatic push(input logic [23:0] w);
      int k;
      k = 0;
      while (result_ready_out !== 1'b1 && k < 100) begin
         @(negedge ref_clk_in);
         k++;
      end
      result_valid_in = 1'b1;
      result_data_in  = w;
      @(negedge ref_clk_in);
      result_valid_in = 1'b0;
   endtask : push

   task automatic wait_rdy(input logic lvl, input int lim, output int k);
      k = 0;
      while (rdy_n_out !== lvl && k < lim) begin
         @(negedge ref_clk_in);
         k++;
      end
   endtask : wait_rdy

   initial begin
      void'($urandom(17184));
      reset_in        = 1'b1;
      standby_n_in    = 1'b1;
      result_valid_in = 1'b0;
      result_data_in  = 24'h000000;
      cal_done_in     = 1'b0;
      repeat (8) @(negedge ref_clk_in);
      reset_in = 1'b0;
      repeat (4) @(negedge ref_clk_in);
      check("rdy_n idle", rdy_n_out, 1);
      check("oe idle", dout_oe_out, 0);
      // register write and read back, all-ones (mode 7FFF) and random values
      for (int k = 0; k < 3; k++) begin
         fv = (k == 0) ? 16'hFFFF : 16'($urandom);
         mv = (k == 0) ? 16'h7FFF : 16'($urandom) & 16'h7FFF;
         d  = (k == 0) ? 24'hFFFFFF : 24'($urandom);
         xfer(1'b0, adc_port_pkg::SEL_FILTER, {8'h00, fv}, 16, v);
         check("filter_out", filter_out, fv);
         xfer(1'b0, adc_port_pkg::SEL_MODE, {8'h00, mv}, 16, v);
         check("mode_out", mode_out, mv);
         xfer(1'b1, adc_port_pkg::SEL_FILTER, 24'h000000, 16, v);
         check("filter read", v[15:0], fv);
         xfer(1'b1, adc_port_pkg::SEL_MODE, 24'h000000, 16, v);
         check("mode read", v[15:0], mv);
         for (int s = 4; s < 6; s++) begin
            xfer(1'b0, 3'(s), d, 24, v);
            xfer(1'b1, 3'(s), 24'h000000, 24, v);
            check("cal reg read", v, d);
         end
      end
      xfer(1'b1, adc_port_pkg::SEL_CMD_STATUS, 24'h000000, 8, v);
      check("status low bits", v[3:0], 0);
      // aborted write leaves filter alone
      serial_host_inst.frame({12'h000, cmd(1'b0, adc_port_pkg::SEL_FILTER), 12'h5A5}, 20, 1'b0, g);
      check("abort keeps filter", filter_out, fv);
      // select held low across frames
      serial_host_inst.frame({8'h00, cmd(1'b0, adc_port_pkg::SEL_FILTER), 16'hA5C3}, 24, 1'b1, g);
      repeat (6) @(negedge ref_clk_in);
      check("oe while selected", dout_oe_out, 1);
      serial_host_inst.frame({8'h00, cmd(1'b1, adc_port_pkg::SEL_FILTER), 16'h0000}, 24, 1'b0, g);
      check("three wire read", g[15:0], 16'hA5C3);
      fv = 16'hA5C3;
      repeat (6) @(negedge ref_clk_in);
      check("oe deselected", dout_oe_out, 0);
      // result, aborted read, full read
      d = 24'($urandom);
      push(d);
      wait_rdy(1'b0, 10, n);
      check("rdy on result", n <= 4, 1);
      serial_host_inst.frame({14'h0000, cmd(1'b1, adc_port_pkg::SEL_DATA), 10'h000}, 18, 1'b0, g);
      check("rdy after partial", rdy_n_out, 0);
      xfer(1'b1, adc_port_pkg::SEL_DATA, 24'h000000, 24, v);
      check("data word", v, d);
      check("rdy after read", rdy_n_out, 1);
      // unread result replaced by newer one
      d = 24'($urandom);
      e = 24'($urandom);
      push(d);
      wait_rdy(1'b0, 10, n);
      push(e);
      wait_rdy(1'b1, 10, n);
      check("rdy up before update", rdy_n_out, 1);
      wait_rdy(1'b0, 200, n);
      check("update hold", n >= adc_port_pkg::HOLD_CYCLES && n <= adc_port_pkg::HOLD_CYCLES + 2, 1);
      xfer(1'b1, adc_port_pkg::SEL_DATA, 24'h000000, 24, v);
      check("newer word", v, e);
      // calibration over a pending result
      push(d);
      wait_rdy(1'b0, 10, n);
      cp = cal_pulses;
      xfer(1'b0, adc_port_pkg::SEL_MODE, 24'h008000 | 24'($urandom & 32'h7FFF), 16, v);
      check("cal request", cal_pulses - cp, 1);
      repeat (5) @(negedge ref_clk_in);
      check("rdy in cal", rdy_n_out, 1);
      cal_done_in = 1'b1;
      @(negedge ref_clk_in);
      cal_done_in = 1'b0;
      wait_rdy(1'b0, 3, n);
      check("rdy cal done", rdy_n_out, 0);
      xfer(1'b0, adc_port_pkg::SEL_MODE, 24'h000000, 16, v);
      // standby freezes the port and keeps registers
      standby_n_in = 1'b0;
      repeat (4) @(negedge ref_clk_in);
      check("standby_out", standby_out, 1);
      serial_host_inst.frame({8'h00, cmd(1'b0, adc_port_pkg::SEL_FILTER), ~fv}, 24, 1'b0, g);
      check("filter frozen", filter_out, fv);
      standby_n_in = 1'b1;
      repeat (4) @(negedge ref_clk_in);
      check("awake", standby_out, 0);
      xfer(1'b1, adc_port_pkg::SEL_FILTER, 24'h000000, 16, v);
      check("filter kept", v[15:0], fv);
      // fill buffer with host stalled, then let updates drain it
      n = 0;
      result_valid_in = 1'b1;
      while (result_ready_out === 1'b1 && n < 40) begin
         d = 24'($urandom);
         result_data_in = d;
         @(negedge ref_clk_in);
         n++;
      end
      result_valid_in = 1'b0;
      check("buffer refuses", n >= adc_port_pkg::FIFO_DEPTH && n < 40, 1);
      repeat (1500) @(negedge ref_clk_in);
      check("buffer drained", result_ready_out, 1);
      xfer(1'b1, adc_port_pkg::SEL_DATA, 24'h000000, 24, v);
      check("last word", v, d);
      report_and_stop();
   end
endmodule : adc_ready_readout_port_tb

`default_nettype wire
